// ---- logic/ucrm_pkg.sv ----
// ucrm_pkg: offsets, field positions, reset values and carriers for the
// per-channel uart register bank.
// assumes a single 100 MHz clock domain and an 8-bit register port.
`default_nettype none
package ucrm_pkg;
  // ****************************************************************
  // register offsets (a3..a0)
  // ****************************************************************
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_IEN = 4'h1;
  localparam logic [3:0] OFF_ISRC = 4'h2;
  localparam logic [3:0] OFF_LCTL = 4'h3;
  localparam logic [3:0] OFF_MCTL = 4'h4;
  localparam logic [3:0] OFF_LSTAT = 4'h5;
  localparam logic [3:0] OFF_MSTAT = 4'h6;
  localparam logic [3:0] OFF_SCR = 4'h7;
  localparam logic [3:0] OFF_FEAT = 4'h8;
  localparam logic [3:0] OFF_ENH = 4'h9;
  localparam logic [3:0] OFF_TXLVL = 4'hA;
  localparam logic [3:0] OFF_RXLVL = 4'hB;
  localparam logic [3:0] OFF_XFLAG = 4'hC;
  localparam logic [3:0] OFF_STOP2 = 4'hD;
  localparam logic [3:0] OFF_RES1 = 4'hE;
  localparam logic [3:0] OFF_RES2 = 4'hF;
  // ****************************************************************
  // field positions and masks
  // ****************************************************************
  localparam int ENH_GATE_BIT = 4;
  localparam int DIV_ACCESS_BIT = 7;
  localparam int LOOPBACK_BIT = 4;
  localparam int CHAN_LSB = 9;
  localparam int CHAN_MSB = 11;
  localparam logic [7:0] IEN_ENH_MASK = 8'hE0;
  localparam logic [7:0] ISRC_ENH_MASK = 8'h30;
  localparam logic [7:0] FCTL_ENH_MASK = 8'h30;
  localparam logic [7:0] MCTL_ENH_MASK = 8'hE4;
  localparam logic [7:0] MSTW_ENH_MASK = 8'hF0;
  localparam logic [7:0] FRAC_MASK = 8'h0F;
  localparam logic [7:0] XFLAG_MASK = 8'h0F;
  localparam logic [1:0] LEGACY_OUT_BITS = 2'h0; // used only to size nothing
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } ucrm_req_t;
  typedef struct packed {
    logic loopback;
    logic [1:0] legacy_out;
    logic [7:0] tx_data;
    logic tx_strobe;
  } ucrm_ctl_t;
endpackage
`default_nettype wire

// ---- logic/ucrm_gate.sv ----
// ucrm_gate: masks the enhanced bits of a byte unless enhanced mode is on.
// assumes the mask comes from the package constants.
`default_nettype none
module ucrm_gate
  import ucrm_pkg::*;
(
  // control
  input wire logic enh_on,
  input wire logic [7:0] mask,
  // data
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  // gated bits read and act as zero while enhanced mode is off
  assign dout = enh_on ? din : (din & ~mask); // R1 R2
endmodule
`default_nettype wire

// ---- logic/ucrm_flags.sv ----
// ucrm_flags: four sticky flow-control character flags, read-to-clear.
// assumes set pulses come from the flow-control logic of the channel.
`default_nettype none
module ucrm_flags
  import ucrm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // events and clear
  input wire logic [3:0] set,
  input wire logic clr,
  output logic [3:0] flags_ff
);
  // a set in the clearing cycle survives so no event is lost
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_ff <= 4'h0;
    end else begin
      flags_ff <= (clr ? 4'h0 : flags_ff) | set; // R3
    end
  end
endmodule
`default_nettype wire

// ---- logic/ucrm_bank.sv ----
// ucrm_bank: register bank of one uart channel with channel decode.
// assumes the host port is synchronous, one access per cycle, read data
// returned one cycle after the read strobe.
//
// Function
// [R1] enhanced bits act only while enhanced-function bit 4 is set; fifo, turnaround and modem bit 2 stored while set act after it clears.
// [R2] gated: int-enable 7:5, source 5:4, fifo 5:4, modem 7:5,2, status-write 7:4.
// [R3] reading the flag register clears the four flow-character flags.
// [R4] legacy user-output bits drive no pin outside the device.
// [R5] legacy user-output bits are stored and used during internal loopback.
// [R6] divisor registers reachable only while line-control bit 7 is one.
// [R7] register from address 3:0, channel from address 11:9.
// [R8] loopback bit 4 routes transmit shift output to receive shift input.
// [R9] fractional divisor keeps four bits, upper four read zero.
`default_nettype none
module ucrm_bank
  import ucrm_pkg::*;
#(
  parameter logic [2:0] CHANNEL = 3'h0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // host register port
  input wire ucrm_req_t req,
  output logic [7:0] rdata_ff,
  output logic rvalid_ff,
  // datapath status in
  input wire logic [7:0] rx_data,
  input wire logic [7:0] int_source,
  input wire logic [7:0] line_status,
  input wire logic [7:0] modem_status,
  input wire logic [7:0] tx_level,
  input wire logic [7:0] rx_level,
  input wire logic [3:0] flow_char_set,
  input wire logic tx_shift_out,
  // datapath control out
  output ucrm_ctl_t ctl_ff,
  output logic [7:0] fifo_control_ff,
  output logic fifo_control_wr_ff,
  output logic [15:0] divisor_ff,
  output logic [3:0] frac_ff,
  output logic [7:0] line_control_ff,
  output logic [7:0] feature_control_ff,
  output logic [7:0] enhanced_function_ff,
  output logic [7:0] turnaround_ff,
  output logic [7:0] tx_thresh_ff,
  output logic [7:0] rx_thresh_ff,
  output logic [31:0] flow_chars_ff,
  output logic rx_shift_in_ff
);
  // ****************************************************************
  // decode
  // ****************************************************************
  logic sel;
  logic dlab;
  logic enh_on;
  logic rd;
  logic wr;
  logic [3:0] off;
  logic [7:0] ien_ff;
  logic [7:0] mctl_ff;
  logic [7:0] scr_ff;
  logic [7:0] ien_view;
  logic [7:0] isrc_view;
  logic [7:0] mctl_view;
  logic [7:0] nxt_rdata;
  logic [3:0] xflags;

  // only the addressed channel answers
  assign sel = (req.addr[CHAN_MSB:CHAN_LSB] == CHANNEL); // R7
  assign off = req.addr[3:0]; // R7
  assign rd = req.rd & sel;
  assign wr = req.wr & sel;
  assign dlab = line_control_ff[DIV_ACCESS_BIT];
  assign enh_on = enhanced_function_ff[ENH_GATE_BIT];

  // ****************************************************************
  // enhanced gating
  // ****************************************************************
  ucrm_gate u_gate_ien (.enh_on(enh_on), .mask(IEN_ENH_MASK), .din(ien_ff),
    .dout(ien_view));
  ucrm_gate u_gate_isrc (.enh_on(enh_on), .mask(ISRC_ENH_MASK), .din(int_source),
    .dout(isrc_view));
  ucrm_gate u_gate_mctl (.enh_on(enh_on), .mask(MCTL_ENH_MASK), .din(mctl_ff),
    .dout(mctl_view));

  // write data with enhanced bits dropped when not permitted
  function automatic logic [7:0] gated(input logic [7:0] d, input logic [7:0] m,
    input logic on);
    gated = on ? d : (d & ~m); // R1 R2
  endfunction

  // ****************************************************************
  // writable registers
  // ****************************************************************
  // divisor shares offsets with data and interrupt enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      divisor_ff <= 16'h0000;
      frac_ff <= 4'h0;
      ien_ff <= RESET_BYTE;
    end else if (wr) begin
      if (dlab && off == OFF_DATA) divisor_ff[7:0] <= req.wdata; // R6
      if (dlab && off == OFF_IEN) divisor_ff[15:8] <= req.wdata; // R6
      if (dlab && off == OFF_ISRC) frac_ff <= req.wdata[3:0]; // R6 R9
      if (!dlab && off == OFF_IEN) ien_ff <= gated(req.wdata, IEN_ENH_MASK, enh_on); // R2
    end
  end

  // transmit byte, strobes and loopback carrier; one process owns all of ctl_ff
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl_ff.tx_data <= RESET_BYTE;
      ctl_ff.tx_strobe <= 1'b0;
      ctl_ff.loopback <= 1'b0;
      ctl_ff.legacy_out <= 2'b00;
      fifo_control_ff <= RESET_BYTE;
      fifo_control_wr_ff <= 1'b0;
    end else begin
      ctl_ff.tx_strobe <= wr && !dlab && off == OFF_DATA; // R6
      ctl_ff.loopback <= mctl_view[LOOPBACK_BIT]; // R8
      // legacy bits are kept only for loopback; no pin is driven by them
      ctl_ff.legacy_out <= mctl_view[LOOPBACK_BIT] ? mctl_ff[3:2] : 2'b00; // R4 R5
      fifo_control_wr_ff <= wr && !dlab && off == OFF_ISRC;
      if (wr && !dlab && off == OFF_DATA) ctl_ff.tx_data <= req.wdata;
      if (wr && !dlab && off == OFF_ISRC) begin
        fifo_control_ff <= gated(req.wdata, FCTL_ENH_MASK, enh_on); // R2
      end
    end
  end

  // plain control registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_control_ff <= RESET_BYTE;
      mctl_ff <= RESET_BYTE;
      scr_ff <= RESET_BYTE;
      feature_control_ff <= RESET_BYTE;
      enhanced_function_ff <= RESET_BYTE;
      turnaround_ff <= RESET_BYTE;
    end else if (wr) begin
      case (off)
        OFF_LCTL: line_control_ff <= req.wdata;
        OFF_MCTL: mctl_ff <= gated(req.wdata, MCTL_ENH_MASK, enh_on); // R2 R5
        OFF_MSTAT: turnaround_ff <= gated(req.wdata, MSTW_ENH_MASK, enh_on); // R2
        OFF_SCR: scr_ff <= req.wdata;
        OFF_FEAT: feature_control_ff <= req.wdata;
        OFF_ENH: enhanced_function_ff <= req.wdata;
        default: ;
      endcase
    end
  end

  // thresholds and flow characters
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_thresh_ff <= RESET_BYTE;
      rx_thresh_ff <= RESET_BYTE;
      flow_chars_ff <= 32'h0000_0000;
    end else if (wr) begin
      case (off)
        OFF_TXLVL: tx_thresh_ff <= req.wdata;
        OFF_RXLVL: rx_thresh_ff <= req.wdata;
        OFF_XFLAG: flow_chars_ff[7:0] <= req.wdata;
        OFF_STOP2: flow_chars_ff[15:8] <= req.wdata;
        OFF_RES1: flow_chars_ff[23:16] <= req.wdata;
        OFF_RES2: flow_chars_ff[31:24] <= req.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // loopback and legacy outputs
  // ****************************************************************
  // receive input idles at mark outside loopback so no false start bit appears
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_shift_in_ff <= 1'b1;
    end else begin
      rx_shift_in_ff <= mctl_view[LOOPBACK_BIT] ? tx_shift_out : 1'b1; // R8
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  ucrm_flags u_flags (.clock(clock), .rst(rst), .set(flow_char_set),
    .clr(rd && off == OFF_XFLAG), .flags_ff(xflags)); // R3

  // read mux; unlisted read offsets return zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (off)
      OFF_DATA: nxt_rdata = dlab ? divisor_ff[7:0] : rx_data; // R6
      OFF_IEN: nxt_rdata = dlab ? divisor_ff[15:8] : ien_view; // R6
      OFF_ISRC: nxt_rdata = dlab ? ({4'h0, frac_ff} & FRAC_MASK) : isrc_view; // R9
      OFF_LCTL: nxt_rdata = line_control_ff;
      OFF_MCTL: nxt_rdata = mctl_view;
      OFF_LSTAT: nxt_rdata = line_status;
      OFF_MSTAT: nxt_rdata = modem_status;
      OFF_SCR: nxt_rdata = scr_ff;
      OFF_FEAT: nxt_rdata = feature_control_ff;
      OFF_ENH: nxt_rdata = enhanced_function_ff;
      OFF_TXLVL: nxt_rdata = tx_level;
      OFF_RXLVL: nxt_rdata = rx_level;
      OFF_XFLAG: nxt_rdata = {4'h0, xflags} & XFLAG_MASK; // R3
      default: nxt_rdata = 8'h00;
    endcase
  end

  // read data registered for a fixed one-cycle latency
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_ff <= RESET_BYTE;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= rd;
      if (rd) rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // read path: fixed latency, read-clear flags and the divisor window
  a_frac_upper_zero: assert property (@(posedge clock) disable iff (rst) // R9
    rd && dlab && off == OFF_ISRC |=> rdata_ff[7:4] == 4'h0)
    else $error("fraction upper bits not zero");
  a_flags_cleared: assert property (@(posedge clock) disable iff (rst) // R3
    rd && off == OFF_XFLAG && flow_char_set == 4'h0 |=> xflags == 4'h0)
    else $error("flags not cleared on read");
  a_flag_set_wins: assert property (@(posedge clock) disable iff (rst) // R3
    rd && off == OFF_XFLAG && flow_char_set != 4'h0 |=> xflags == $past(flow_char_set))
    else $error("flag event lost in clearing read");
  a_flag_read: assert property (@(posedge clock) disable iff (rst) // R3
    rd && off == OFF_XFLAG |=> rdata_ff == {4'h0, $past(xflags)})
    else $error("flag register read wrong");
  a_dlab_read: assert property (@(posedge clock) disable iff (rst) // R6
    rd && dlab && off == OFF_IEN |=> rdata_ff == $past(divisor_ff[15:8]))
    else $error("divisor high read wrong");
  a_chan_select: assert property (@(posedge clock) disable iff (rst) // R7
    req.rd && req.addr[CHAN_MSB:CHAN_LSB] != CHANNEL |=> !rvalid_ff)
    else $error("wrong channel answered");
  a_rvalid_read: assert property (@(posedge clock) disable iff (rst) // R7
    rd |=> rvalid_ff)
    else $error("own channel read not answered");

  // write gating and divisor writes: enhanced bits land as zero while the gate is off
  a_ien_gated: assert property (@(posedge clock) disable iff (rst) // R1
    !enh_on |-> (ien_view & IEN_ENH_MASK) == 8'h00)
    else $error("enhanced interrupt enable leaked");
  a_isrc_gated: assert property (@(posedge clock) disable iff (rst) // R1
    !enh_on |-> (isrc_view & ISRC_ENH_MASK) == 8'h00)
    else $error("enhanced interrupt source leaked");
  a_mctl_gated: assert property (@(posedge clock) disable iff (rst) // R2
    !enh_on |-> (mctl_view & MCTL_ENH_MASK) == 8'h00)
    else $error("enhanced modem control leaked");
  a_ien_write: assert property (@(posedge clock) disable iff (rst) // R2
    wr && !enh_on && !dlab && off == OFF_IEN |=> (ien_ff & IEN_ENH_MASK) == 8'h00)
    else $error("enhanced interrupt enable stored");
  a_fifo_write: assert property (@(posedge clock) disable iff (rst) // R2
    wr && !enh_on && !dlab && off == OFF_ISRC |=> (fifo_control_ff & FCTL_ENH_MASK) == 8'h00)
    else $error("enhanced fifo control stored");
  a_turn_write: assert property (@(posedge clock) disable iff (rst) // R2
    wr && !enh_on && off == OFF_MSTAT |=> (turnaround_ff & MSTW_ENH_MASK) == 8'h00)
    else $error("enhanced turnaround bits stored");
  a_div_write: assert property (@(posedge clock) disable iff (rst) // R6
    wr && dlab && off == OFF_DATA |=> divisor_ff[7:0] == $past(req.wdata))
    else $error("divisor low not written");
  a_div_keep: assert property (@(posedge clock) disable iff (rst) // R6
    wr && !dlab |=> divisor_ff == $past(divisor_ff))
    else $error("divisor changed outside divisor access");
  a_frac_write: assert property (@(posedge clock) disable iff (rst) // R9
    wr && dlab && off == OFF_ISRC |=> frac_ff == $past(req.wdata[3:0]))
    else $error("fraction not written");

  // loopback, legacy bits and transmit strobe
  a_loop_route: assert property (@(posedge clock) disable iff (rst) // R8
    mctl_view[LOOPBACK_BIT] |=> rx_shift_in_ff == $past(tx_shift_out))
    else $error("loopback route wrong");
  a_legacy_quiet: assert property (@(posedge clock) disable iff (rst) // R4
    !ctl_ff.loopback |-> ctl_ff.legacy_out == 2'b00)
    else $error("legacy outputs active outside loopback");
  a_legacy_loop: assert property (@(posedge clock) disable iff (rst) // R5
    ctl_ff.loopback |-> ctl_ff.legacy_out == $past(mctl_ff[3:2]))
    else $error("legacy bits missing in loopback");
  a_legacy_store: assert property (@(posedge clock) disable iff (rst) // R5
    wr && off == OFF_MCTL |=> mctl_ff[3] == $past(req.wdata[3]))
    else $error("legacy bit not stored");
  a_no_tx_in_dlab: assert property (@(posedge clock) disable iff (rst) // R6
    wr && dlab && off == OFF_DATA |=> !ctl_ff.tx_strobe)
    else $error("transmit strobe during divisor access");
  a_tx_strobe: assert property (@(posedge clock) disable iff (rst) // R6
    wr && !dlab && off == OFF_DATA |=> ctl_ff.tx_strobe && ctl_ff.tx_data == $past(req.wdata))
    else $error("transmit byte not passed on");

  // main scenarios
  c_flag_read: cover property (@(posedge clock) rd && off == OFF_XFLAG && xflags != 4'h0);
  c_set_on_clear: cover property (@(posedge clock) rd && off == OFF_XFLAG && flow_char_set != 4'h0);
  c_div_read: cover property (@(posedge clock) rd && dlab && off == OFF_ISRC);
  c_loopback: cover property (@(posedge clock) ctl_ff.loopback && mctl_ff[3:2] != 2'b00);
endmodule
`default_nettype wire

// ---- testbench/ucrm_host.sv ----
// ucrm_host: host side model issuing single register accesses.
// assumes the bank answers a read with rvalid_ff one cycle later.
`default_nettype none
module ucrm_host
  import ucrm_pkg::*;
(
  // clock
  input wire logic clock,
  // register port
  output ucrm_req_t req,
  input wire logic [7:0] rdata_ff,
  input wire logic rvalid_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // one write strobe; on release addr and data flip so stale values never look valid
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // one read strobe, then a bounded wait for the answer
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic ok);
    @(posedge clock);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
    ok = 1'b0;
    d = 8'h00;
    for (int n = 0; n < 3; n++) begin
      #1;
      if (rvalid_ff === 1'b1) begin
        d = rdata_ff;
        ok = 1'b1;
        break;
      end
      @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench/uart_channel_register_map_tb.sv ----
// uart_channel_register_map_tb: self-checking bench for one channel bank.
// assumes channel 0 and the host model in ucrm_host.
`default_nettype none
module uart_channel_register_map_tb
  import ucrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  ucrm_req_t req;
  logic [7:0] rdata_ff, isrc, mstat, rdat;
  logic rvalid_ff, tx_so, rx_si;
  logic [3:0] fset, frac;
  logic [15:0] div;
  logic [7:0] fctl, turn;
  logic [7:0] lctl, feat, enh, txth, rxth;
  logic [31:0] fchars;
  logic fwr;
  ucrm_ctl_t ctl;
  int bad_count = 0;
  int total_checks = 0;
  always #5 clock = ~clock;
  ucrm_host i_host (.clock(clock), .req(req), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff));
  ucrm_bank #(.CHANNEL(3'h0)) i_dut (
    .clock(clock), .rst(rst), .req(req), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff),
    .rx_data(rdat), .int_source(isrc), .line_status(8'h60), .modem_status(mstat),
    .tx_level(8'h05), .rx_level(8'h07), .flow_char_set(fset), .tx_shift_out(tx_so),
    .ctl_ff(ctl), .fifo_control_ff(fctl), .fifo_control_wr_ff(fwr), .divisor_ff(div),
    .frac_ff(frac), .line_control_ff(lctl), .feature_control_ff(feat),
    .enhanced_function_ff(enh), .turnaround_ff(turn), .tx_thresh_ff(txth),
    .rx_thresh_ff(rxth), .flow_chars_ff(fchars),
    .rx_shift_in_ff(rx_si));
  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // write to channel 0, then let the edge's updates land
  task automatic w(input logic [3:0] off, input logic [7:0] d);
    i_host.wr({8'h00, off}, d);
    #1;
  endtask
  // a missing answer counts as a mismatch and ends the run
  task automatic r(input logic [3:0] off, input logic [7:0] exp, input string what);
    logic [7:0] d;
    logic ok;
    i_host.rd({8'h00, off}, d, ok);
    if (ok !== 1'b1) begin
      chk({what, " answer"}, 16'h0000, 16'h0001);
      end_sim();
    end else begin
      chk(what, d, exp);
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // enhanced bits written and read with the gate off, then on
  task automatic t_gate(input logic [7:0] enhanced_function);
    logic on;
    on = enhanced_function[4];
    w(OFF_ENH, enhanced_function);
    w(OFF_IEN, 8'hEF);
    r(OFF_IEN, on ? 8'hEF : 8'h0F, "int enable");
    w(OFF_MCTL, 8'hEC);
    r(OFF_MCTL, on ? 8'hEC : 8'h08, "modem ctl");
    r(OFF_ISRC, on ? 8'hFF : 8'hCF, "int source");
    w(OFF_ISRC, 8'hFF);
    chk("fifo ctl", fctl, on ? 8'hFF : 8'hCF);
    chk("fifo strobe", fwr, 16'h0001);
    w(OFF_MSTAT, 8'hFC);
    chk("turnaround", turn, on ? 8'hFC : 8'h0C);
    r(OFF_MSTAT, 8'hA5, "modem status");
  endtask
  // divisor window opened and closed by the access bit
  task automatic t_div();
    w(OFF_LCTL, 8'h80);
    w(OFF_DATA, 8'h34);
    chk("no tx strobe", ctl.tx_strobe, 16'h0000);
    w(OFF_IEN, 8'h12);
    w(OFF_ISRC, 8'hFF);
    chk("no fifo strobe", fwr, 16'h0000);
    r(OFF_DATA, 8'h34, "div low");
    r(OFF_IEN, 8'h12, "div high");
    r(OFF_ISRC, 8'h0F, "div frac");
    chk("divisor", div, 16'h1234);
    chk("frac", frac, 16'h000F);
    w(OFF_LCTL, 8'h03);
    w(OFF_DATA, 8'h55);
    chk("tx data", ctl.tx_data, 8'h55);
    chk("tx strobe", ctl.tx_strobe, 16'h0001);
    chk("divisor kept", div, 16'h1234);
    r(OFF_IEN, 8'hEF, "ien back");
    r(OFF_DATA, 8'h5A, "rx data");
  endtask
  // flags set by an event, cleared by the first read
  task automatic t_flags();
    @(posedge clock);
    fset <= 4'hF;
    @(posedge clock);
    fset <= 4'h0;
    r(OFF_XFLAG, 8'h0F, "flags set");
    r(OFF_XFLAG, 8'h00, "flags cleared");
    // an event in the clearing cycle must survive the read
    fork
      r(OFF_XFLAG, 8'h00, "flags on clear");
      begin
        @(posedge clock);
        fset <= 4'h5;
        @(posedge clock);
        fset <= 4'h0;
      end
    join
    r(OFF_XFLAG, 8'h05, "set wins");
  endtask
  // plain registers reach their outputs; read-only offsets show the status inputs
  task automatic t_plain();
    w(OFF_FEAT, 8'hA1);
    w(OFF_TXLVL, 8'h20);
    w(OFF_RXLVL, 8'h30);
    w(OFF_XFLAG, 8'h11);
    w(OFF_STOP2, 8'h13);
    w(OFF_RES1, 8'h22);
    w(OFF_RES2, 8'h24);
    chk("feature", feat, 16'h00A1);
    chk("tx thresh", txth, 16'h0020);
    chk("rx thresh", rxth, 16'h0030);
    chk("chars low", fchars[15:0], 16'h1311);
    chk("chars high", fchars[31:16], 16'h2422);
    chk("line ctl", lctl, 16'h0003);
    chk("enh", enh, 16'h0010);
    r(OFF_FEAT, 8'hA1, "feature rd");
    r(OFF_TXLVL, 8'h05, "tx level");
    r(OFF_RXLVL, 8'h07, "rx level");
    r(OFF_LSTAT, 8'h60, "line status");
    r(OFF_RES2, 8'h00, "offset f read");
  endtask
  // reset in mid-run returns the registers to zero and the loop input to mark
  task automatic t_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("div after reset", div, 16'h0000);
    chk("rx after reset", rx_si, 16'h0001);
    r(OFF_ENH, 8'h00, "enh after reset");
  endtask
  // loopback carries the legacy bits and the serial stream
  task automatic t_loop();
    w(OFF_MCTL, 8'h1C);
    @(posedge clock);
    #1;
    chk("loopback", ctl.loopback, 16'h0001);
    chk("legacy in loop", ctl.legacy_out, 16'h0003);
    for (int v = 0; v < 2; v++) begin
      @(posedge clock);
      tx_so <= v[0];
      @(posedge clock);
      #1;
      chk("rx shift in", rx_si, v[0]);
    end
    w(OFF_MCTL, 8'h0C);
    @(posedge clock);
    tx_so <= 1'b0;
    @(posedge clock);
    #1;
    chk("legacy off loop", ctl.legacy_out, 16'h0000);
    chk("rx idle", rx_si, 16'h0001);
    r(OFF_MCTL, 8'h0C, "legacy stored");
  endtask
  // channel select from 11:9, register from 3:0 only
  task automatic t_chan();
    logic [7:0] d;
    logic ok;
    i_host.wr(12'h1F7, 8'h3C);
    i_host.wr(12'h207, 8'hAA);
    i_host.rd(12'h207, d, ok);
    chk("other channel", ok, 16'h0000);
    r(OFF_SCR, 8'h3C, "scratch");
  endtask
  initial begin
    fset = 4'h0;
    tx_so = 1'b1;
    rdat = 8'h5A;
    isrc = 8'hFF;
    mstat = 8'hA5;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_gate(8'h00);
    t_gate(8'h10);
    t_div();
    t_flags();
    t_plain();
    t_loop();
    t_chan();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
